//--- rtl/rtcwd_top.sv
// Clock-calendar, pin-enabled watchdog and power-down sequencer.
// Assumes a 20 MHz core clock on a supply that stays up in power-down,
// a free-running 32768 Hz crystal square wave on a pin, and software
// controls as plain same-clock strobes.
`default_nettype none

module rtcwd_top
  import rtcwd_pkg::*;
#(
  parameter int WDOG_CYCLES = WDOG_TIMEOUT_CYC // Shorten for simulation
) (
  input wire logic core_clk_i,              // 20 MHz clock
  input wire logic srst_i,                  // Sync reset, active high
  input wire logic xtal_i,                  // 32768 Hz crystal, async
  input wire logic watchdog_enable_pin_i,   // Watchdog enable pin, async
  input wire logic wdog_refresh_i,          // Refresh strobe from software
  input wire logic wdog_flag_clr_i,         // Clear watchdog reset flag
  input wire logic ms_wr_i,                 // Load milliseconds counter
  input wire logic [MS_W-1:0] ms_wdata_i,   // Milliseconds load value
  input wire logic wk_wr_i,                 // Load weeks counter
  input wire logic [WK_W-1:0] wk_wdata_i,   // Weeks load value
  input wire logic pd_req_i,                // Enter power-down strobe
  input wire logic pd_pll_stop_i,           // Also stop PLL in power-down
  input wire logic [ALARM_W-1:0] alarm_i,   // Wake delay in 1.024 kHz ticks
  output logic [MS_W-1:0] ms_count_o,       // Milliseconds count
  output logic [WK_W-1:0] wk_count_o,       // Weeks count
  output logic sys_rst_o,                   // System reset request
  output logic watchdog_reset_flag_o,       // Last reset was the watchdog
  output logic cpu_clk_en_o,                // Processor and peripheral clock gate
  output logic pll_run_o,                   // PLL run enable
  output logic wake_o                       // One-cycle wake pulse
);

  localparam logic [31:0] WDOG_LAST = 32'(WDOG_CYCLES - 1);
  localparam logic [4:0] XTAL_LAST = 5'(XTAL_PER_MS - 1);
  localparam logic [4:0] SYS_RST_LAST = 5'(SYS_RST_CYC - 1);

  rtcwd_cal_if cal_if ();

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic xtal_meta_q, xtal_sync_q, xtal_prev_q;
  logic wden_meta_q, wden_sync_q;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      xtal_meta_q <= 1'b0;
      xtal_sync_q <= 1'b0;
      xtal_prev_q <= 1'b0;
    end else begin
      xtal_meta_q <= xtal_i;
      xtal_sync_q <= xtal_meta_q;
      xtal_prev_q <= xtal_sync_q;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      wden_meta_q <= 1'b0;
      wden_sync_q <= 1'b0;
    end else begin
      wden_meta_q <= watchdog_enable_pin_i;
      wden_sync_q <= wden_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // Crystal divider to 1.024 kHz
  // ---------------------------------------------------------------
  logic xtal_rise;
  logic [4:0] xdiv_q;
  logic ms_tick_q;

  assign xtal_rise = xtal_sync_q && !xtal_prev_q; // [R6]

  // Divider runs regardless of power state so time is never lost
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      xdiv_q <= 5'h00;
      ms_tick_q <= 1'b0;
    end else begin
      ms_tick_q <= xtal_rise && (xdiv_q == XTAL_LAST); // [R9]
      if (xtal_rise) begin
        xdiv_q <= (xdiv_q == XTAL_LAST) ? 5'h00 : xdiv_q + 5'h01; // [R6]
      end
    end
  end

  // ---------------------------------------------------------------
  // Calendar
  // ---------------------------------------------------------------
  assign cal_if.ms_tick = ms_tick_q; // [R7]
  assign cal_if.ms_wr = ms_wr_i;
  assign cal_if.ms_wdata = ms_wdata_i;
  assign cal_if.wk_wr = wk_wr_i;
  assign cal_if.wk_wdata = wk_wdata_i;

  rtcwd_calendar u_calendar (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .cal(cal_if.cal)
  );

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ms_count_o <= MS_RESET;
      wk_count_o <= WK_RESET;
    end else begin
      ms_count_o <= cal_if.ms_count;
      wk_count_o <= cal_if.wk_count;
    end
  end

  // ---------------------------------------------------------------
  // Power-down sequencer
  // ---------------------------------------------------------------
  rtcwd_pwr_state_type pwr_q;
  logic [ALARM_W-1:0] alarm_q;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pwr_q <= PWR_RUN;
      alarm_q <= 32'h00000000;
    end else begin
      case (pwr_q)
        PWR_RUN: begin
          if (pd_req_i) begin
            alarm_q <= alarm_i;
            pwr_q <= PWR_DOWN; // [R11]
          end
        end
        PWR_DOWN: begin
          if (alarm_q == 32'h00000000) begin
            pwr_q <= PWR_WAKE; // [R10]
          end else if (ms_tick_q) begin
            alarm_q <= alarm_q - 32'h00000001; // [R10]
          end
        end
        PWR_WAKE: begin
          pwr_q <= PWR_RUN; // [R12]
        end
        default: begin
          pwr_q <= PWR_RUN;
        end
      endcase
    end
  end

  // Gating only, no reset: all held state survives the stop
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cpu_clk_en_o <= 1'b1;
      pll_run_o <= 1'b1;
      wake_o <= 1'b0;
    end else begin
      wake_o <= (pwr_q == PWR_WAKE); // [R10]
      if (pwr_q == PWR_RUN && pd_req_i) begin
        cpu_clk_en_o <= 1'b0; // [R11]
        pll_run_o <= !pd_pll_stop_i; // [R11]
      end else if (pwr_q == PWR_WAKE) begin
        cpu_clk_en_o <= 1'b1; // [R12]
        pll_run_o <= 1'b1; // [R12]
      end
    end
  end

  // ---------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------
  rtcwd_wd_state_type wd_q;
  logic [31:0] wd_cnt_q;
  logic [4:0] rst_cnt_q;
  logic wd_fire;

  // Counter pauses in power-down since the processor cannot refresh it
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      wd_q <= WD_OFF;
      wd_cnt_q <= 32'h00000000;
      rst_cnt_q <= 5'h00;
    end else begin
      case (wd_q)
        WD_OFF: begin
          wd_cnt_q <= 32'h00000000;
          if (wden_sync_q) begin
            wd_q <= WD_COUNT; // [R1]
          end
        end
        WD_COUNT: begin
          if (!wden_sync_q) begin
            wd_q <= WD_OFF; // [R1]
          end else if (wdog_refresh_i) begin
            wd_cnt_q <= 32'h00000000; // [R13]
          end else if (wd_cnt_q == WDOG_LAST) begin
            rst_cnt_q <= 5'h00;
            wd_q <= WD_FIRE; // [R3]
          end else if (pwr_q == PWR_RUN) begin
            wd_cnt_q <= wd_cnt_q + 32'h00000001; // [R3]
          end
        end
        WD_FIRE: begin
          wd_cnt_q <= 32'h00000000;
          rst_cnt_q <= rst_cnt_q + 5'h01;
          if (rst_cnt_q == SYS_RST_LAST) begin
            wd_q <= WD_COUNT; // [R2]
          end
        end
        default: begin
          wd_q <= WD_OFF;
        end
      endcase
    end
  end

  assign wd_fire = (wd_q == WD_FIRE);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sys_rst_o <= 1'b0;
    end else begin
      sys_rst_o <= wd_fire; // [R2]
    end
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      watchdog_reset_flag_o <= 1'b0;
    end else if (wd_fire) begin
      watchdog_reset_flag_o <= 1'b1; // [R4]
    end else if (wdog_flag_clr_i) begin
      watchdog_reset_flag_o <= 1'b0;
    end
  end

endmodule : rtcwd_top

`default_nettype wire

//--- inc/rtcwd_pkg.sv
// Constants and types shared by the clock-calendar, watchdog and power-down logic.
// Assumes a single 20 MHz core clock and a crystal tick pin sampled on it.
//
// Summary of operation
// R1 - Watchdog acts only while enable pin high
// R2 - Watchdog timeout resets the whole system
// R3 - Watchdog timeout interval nominally two seconds
// R4 - Watchdog reset sets a readable status flag
// R5 - Calendar counters run; writes load new values
// R6 - Calendar timed from 32768 Hz crystal ticks
// R7 - Calendar keeps counting during power-down
// R8 - Calendar: 30-bit milliseconds, 16-bit weeks
// R9 - Milliseconds counter advances at 1.024 kHz
// R10 - Alarm runs in power-down, wakes CPU
// R11 - Power-down stops processor, peripherals, optionally PLL
// R12 - Leaving power-down resumes with state intact
// R13 - Software refreshes watchdog before timeout
// R14 - Weeks advance when milliseconds complete one week
`default_nettype none

package rtcwd_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CORE_CLK_HZ = 20_000_000;
  localparam int XTAL_HZ = 32_768;
  localparam int MS_TICK_HZ = 1_024;
  localparam int XTAL_PER_MS = XTAL_HZ / MS_TICK_HZ;
  localparam int WDOG_TIMEOUT_S = 2;
  localparam int WDOG_TIMEOUT_CYC = WDOG_TIMEOUT_S * CORE_CLK_HZ;
  localparam int SYS_RST_CYC = 16;

  // ---------------------------------------------------------------
  // Calendar layout
  // ---------------------------------------------------------------
  localparam int MS_W = 30;
  localparam int WK_W = 16;
  localparam int SEC_PER_WEEK = 7 * 24 * 3600;
  localparam logic [MS_W-1:0] MS_PER_WEEK = MS_W'(MS_TICK_HZ * SEC_PER_WEEK);
  localparam logic [MS_W-1:0] MS_RESET = 30'h0000000;
  localparam logic [WK_W-1:0] WK_RESET = 16'h0000;
  localparam int ALARM_W = 32;

  // ---------------------------------------------------------------
  // State machines
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {WD_OFF, WD_COUNT, WD_FIRE} rtcwd_wd_state_type;
  typedef enum logic [1:0] {PWR_RUN, PWR_DOWN, PWR_WAKE} rtcwd_pwr_state_type;

endpackage : rtcwd_pkg

`default_nettype wire

//--- inc/rtcwd_cal_if.sv
// Link between the supervision top and its calendar counter module.
// Assumes both ends share the core clock.
`default_nettype none

interface rtcwd_cal_if;
  import rtcwd_pkg::*;
  logic ms_tick;
  logic ms_wr;
  logic [MS_W-1:0] ms_wdata;
  logic wk_wr;
  logic [WK_W-1:0] wk_wdata;
  logic [MS_W-1:0] ms_count;
  logic [WK_W-1:0] wk_count;

  modport ctrl (output ms_tick, ms_wr, ms_wdata, wk_wr, wk_wdata, input ms_count, wk_count);
  modport cal (input ms_tick, ms_wr, ms_wdata, wk_wr, wk_wdata, output ms_count, wk_count);
endinterface : rtcwd_cal_if

`default_nettype wire

//--- rtl/rtcwd_calendar.sv
// Milliseconds and weeks counters of the clock-calendar.
// Assumes a one-cycle 1.024 kHz tick and software loads from the core domain.
`default_nettype none

module rtcwd_calendar
  import rtcwd_pkg::*;
(
  input wire logic core_clk_i, // Core clock
  input wire logic srst_i,     // Sync reset, active high
  rtcwd_cal_if.cal cal         // Tick, loads and counts
);

  logic [MS_W-1:0] ms_q;
  logic [WK_W-1:0] wk_q;
  logic week_done;

  // Milliseconds wrap is a week boundary; counted in 1.024 kHz ticks
  assign week_done = cal.ms_tick && (ms_q == MS_PER_WEEK - 30'h0000001);

  // ---------------------------------------------------------------
  // Milliseconds counter
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ms_q <= MS_RESET;
    end else if (cal.ms_wr) begin
      ms_q <= cal.ms_wdata; // [R5]
    end else if (week_done) begin
      ms_q <= MS_RESET; // [R14]
    end else if (cal.ms_tick) begin
      ms_q <= ms_q + 30'h0000001; // [R9]
    end
  end

  // ---------------------------------------------------------------
  // Weeks counter
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      wk_q <= WK_RESET;
    end else if (cal.wk_wr) begin
      wk_q <= cal.wk_wdata; // [R5]
    end else if (week_done && !cal.ms_wr) begin
      wk_q <= wk_q + 16'h0001; // [R14]
    end
  end

  assign cal.ms_count = ms_q; // [R8]
  assign cal.wk_count = wk_q; // [R8]

endmodule : rtcwd_calendar

`default_nettype wire

//--- testbench/rtcwd_top_sva.sv
// Checker for the supervision top: watchdog, calendar loads, power-down.
// Assumes it is bound to rtcwd_top and sees only its ports.
`default_nettype none

module rtcwd_top_sva
  import rtcwd_pkg::*;
#(
  parameter int WDOG_CYCLES = WDOG_TIMEOUT_CYC // Watchdog count
) (
  input wire logic core_clk_i,            // Clock
  input wire logic srst_i,                // Reset
  input wire logic watchdog_enable_pin_i, // Enable pin
  input wire logic wdog_refresh_i,        // Refresh
  input wire logic wdog_flag_clr_i,       // Flag clear
  input wire logic ms_wr_i,               // Ms load
  input wire logic [MS_W-1:0] ms_wdata_i, // Ms value
  input wire logic wk_wr_i,               // Weeks load
  input wire logic [WK_W-1:0] wk_wdata_i, // Weeks value
  input wire logic pd_req_i,              // Power-down
  input wire logic pd_pll_stop_i,         // PLL stop
  input wire logic [MS_W-1:0] ms_count_o, // Ms count
  input wire logic [WK_W-1:0] wk_count_o, // Weeks count
  input wire logic sys_rst_o,             // System reset
  input wire logic watchdog_reset_flag_o, // Flag
  input wire logic cpu_clk_en_o,          // Clock gate
  input wire logic pll_run_o,             // PLL run
  input wire logic wake_o                 // Wake pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  // ---------------------------------------------------------------
  // Helper counters
  // ---------------------------------------------------------------
  logic [31:0] gap_q;
  logic [4:0] len_q;

  // Frozen in power-down, like the watchdog count
  always_ff @(posedge core_clk_i) begin
    if (srst_i || sys_rst_o || wdog_refresh_i || !watchdog_enable_pin_i) begin
      gap_q <= 32'h0;
    end else if (cpu_clk_en_o) begin
      gap_q <= gap_q + 32'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i || !sys_rst_o) begin
      len_q <= 5'h0;
    end else begin
      len_q <= len_q + 5'h1;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_pin_off_quiet: assert property (!watchdog_enable_pin_i [*6] |-> !$rose(sys_rst_o))
    else $error("system reset raised while watchdog pin low");
  a_wdog_interval: assert property (
    $rose(sys_rst_o) |-> gap_q >= WDOG_CYCLES - 2 && gap_q <= WDOG_CYCLES + 8)
    else $error("watchdog timeout interval wrong");
  a_rst_length: assert property ($fell(sys_rst_o) |-> len_q == 5'h10)
    else $error("system reset pulse length wrong");
  a_flag_set: assert property ($rose(sys_rst_o) |-> watchdog_reset_flag_o)
    else $error("flag not set by watchdog reset");
  a_flag_hold: assert property (
    watchdog_reset_flag_o && !wdog_flag_clr_i |=> watchdog_reset_flag_o)
    else $error("flag dropped without clear");
  // Set beats clear for as long as the reset pulse is being driven
  a_flag_clear: assert property (
    wdog_flag_clr_i |=> !watchdog_reset_flag_o || sys_rst_o)
    else $error("flag not cleared");
  a_ms_load: assert property (ms_wr_i |-> ##2 ms_count_o == $past(ms_wdata_i, 2))
    else $error("ms load value not shown");
  a_wk_load: assert property (wk_wr_i |-> ##2 wk_count_o == $past(wk_wdata_i, 2))
    else $error("weeks load value not shown");
  a_ms_step: assert property (
    !$past(ms_wr_i, 2) && $changed(ms_count_o)
      |-> ms_count_o == $past(ms_count_o) + 30'h0000001 || ms_count_o == 30'h0000000)
    else $error("ms count jumped");
  a_pd_enter: assert property (
    pd_req_i && cpu_clk_en_o |=> !cpu_clk_en_o && pll_run_o == !$past(pd_pll_stop_i))
    else $error("power-down entry wrong");
  a_wake_pulse: assert property ($rose(cpu_clk_en_o) |-> wake_o ##1 !wake_o)
    else $error("wake pulse wrong");

  c_wdog_fire: cover property ($rose(sys_rst_o));
  c_pd_enter: cover property (pd_req_i && cpu_clk_en_o);
  c_wake: cover property (wake_o);
endmodule : rtcwd_top_sva

bind rtcwd_top rtcwd_top_sva #(.WDOG_CYCLES(WDOG_CYCLES)) i_sva (.core_clk_i, .srst_i,
  .watchdog_enable_pin_i, .wdog_refresh_i, .wdog_flag_clr_i, .ms_wr_i, .ms_wdata_i, .wk_wr_i,
  .wk_wdata_i, .pd_req_i, .pd_pll_stop_i, .ms_count_o, .wk_count_o, .sys_rst_o,
  .watchdog_reset_flag_o, .cpu_clk_en_o, .pll_run_o, .wake_o);

`default_nettype wire

//--- testbench/tb_rtcwd_top.sv
// Self-checking bench for the clock-calendar, watchdog and power-down top.
// Assumes a shortened watchdog count and a fast square wave on the crystal pin.
`default_nettype none

module tb_rtcwd_top
  import rtcwd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WD = 200;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic xtal = 1'b0, pin = 1'b0, refr = 1'b0, fclr = 1'b0;
  logic ms_wr = 1'b0, wk_wr = 1'b0, pd_req = 1'b0, pll_stop = 1'b0;
  logic [MS_W-1:0] ms_d = '0, ms_q;
  logic [WK_W-1:0] wk_d = '0, wk_q;
  logic [ALARM_W-1:0] alarm = '0;
  logic sys_rst, flag, cpu_en, pll_run, wake;
  int fail_count = 0, tests_run = 0, rst_cyc = 0, woke = 0, n = 0;
  logic [MS_W+WK_W-1:0] rows [4] = '{{30'h0000000, 16'h0000}, {30'h3FFFFFFF, 16'hFFFF},
    {30'h2AAAAAAA, 16'h5555}, {MS_PER_WEEK - 30'h1, 16'h8001}};

  always #25 core_clk_i = ~core_clk_i;

  rtcwd_top #(.WDOG_CYCLES(WD)) i_dut (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .xtal_i(xtal), .watchdog_enable_pin_i(pin),
    .wdog_refresh_i(refr), .wdog_flag_clr_i(fclr), .ms_wr_i(ms_wr), .ms_wdata_i(ms_d),
    .wk_wr_i(wk_wr), .wk_wdata_i(wk_d), .pd_req_i(pd_req), .pd_pll_stop_i(pll_stop),
    .alarm_i(alarm), .ms_count_o(ms_q), .wk_count_o(wk_q), .sys_rst_o(sys_rst),
    .watchdog_reset_flag_o(flag), .cpu_clk_en_o(cpu_en), .pll_run_o(pll_run), .wake_o(wake)
  );

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic tick(input int c);
    repeat (c) begin
      @(posedge core_clk_i);
      #5;
      rst_cyc += int'(sys_rst);
      woke += int'(wake);
    end
  endtask : tick

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic load(input logic [MS_W-1:0] m, input logic [WK_W-1:0] w);
    ms_d = m;
    wk_d = w;
    ms_wr = 1'b1;
    wk_wr = 1'b1;
    tick(1);
    ms_wr = 1'b0;
    wk_wr = 1'b0;
    tick(2);
  endtask : load

  // Fast stand-in for the crystal keeps the run short
  task automatic xedges(input int c);
    repeat (c) begin
      xtal = 1'b1;
      tick(4);
      xtal = 1'b0;
      tick(4);
    end
  endtask : xedges

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  task automatic wait_rst;
    n = 0;
    while (sys_rst !== 1'b1 && n < WD + 20) begin
      tick(1);
      n++;
    end
    if (sys_rst !== 1'b1) begin
      fail_count++;
      $display("[FAIL] sys_rst expected 1 seen %b", sys_rst);
      stop_test();
    end
  endtask : wait_rst

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    tick(3);
    srst_i = 1'b0;
    tick(1);
    chk("reset_outs", 32'h6, 32'({sys_rst, flag, cpu_en, pll_run, wake}));
    chk("reset_ms", 32'h0, 32'(ms_q));
    foreach (rows[i]) begin
      load(rows[i][45:16], rows[i][15:0]);
      chk("ms_load", 32'(rows[i][45:16]), 32'(ms_q));
      chk("wk_load", 32'(rows[i][15:0]), 32'(wk_q));
    end
    $display("test loads done");
    load(30'h64, 16'h7);
    xedges(31);
    tick(8);
    chk("ms_31_edges", 32'h64, 32'(ms_q));
    xedges(1);
    tick(8);
    chk("ms_32_edges", 32'h65, 32'(ms_q));
    load(MS_PER_WEEK - 30'h1, 16'hFFFF);
    xedges(32);
    tick(8);
    chk("ms_wrap", 32'h0, 32'(ms_q));
    chk("wk_wrap", 32'h0, 32'(wk_q));
    $display("test ticks done");
    rst_cyc = 0;
    tick(WD + 50);
    chk("rst_pin_low", 32'h0, rst_cyc);
    pin = 1'b1;
    repeat (4) begin
      tick(WD - 50);
      refr = 1'b1;
      tick(1);
      refr = 1'b0;
    end
    chk("rst_refreshed", 32'h0, rst_cyc);
    wait_rst();
    chk("wd_interval", 32'h1, {31'h0, (n >= WD && n <= WD + 2)});
    chk("flag_set", 32'h1, 32'(flag));
    rst_cyc = 1;
    fclr = 1'b1;
    tick(1);
    fclr = 1'b0;
    chk("flag_set_wins", 32'h1, 32'(flag));
    tick(19);
    pin = 1'b0;
    chk("rst_len", 32'h10, rst_cyc);
    chk("flag_sticky", 32'h1, 32'(flag));
    fclr = 1'b1;
    tick(1);
    fclr = 1'b0;
    tick(1);
    chk("flag_clr", 32'h0, 32'(flag));
    $display("test watchdog done");
    alarm = 32'h4;
    pll_stop = 1'b1;
    pd_req = 1'b1;
    tick(1);
    pd_req = 1'b0;
    tick(1);
    chk("pd_gate", 32'h0, 32'({cpu_en, pll_run}));
    pll_stop = 1'b0;
    pd_req = 1'b1;
    tick(1);
    pd_req = 1'b0;
    woke = 0;
    xedges(96);
    chk("pd_hold", 32'h0, {30'h0, cpu_en, pll_run});
    chk("ms_in_pd", 32'h3, 32'(ms_q));
    xedges(32);
    tick(8);
    chk("wake_pulse", 32'h1, woke);
    chk("resume", 32'h3, {30'h0, cpu_en, pll_run});
    chk("ms_resume", 32'h4, 32'(ms_q));
    alarm = 32'h0;
    pd_req = 1'b1;
    tick(1);
    pd_req = 1'b0;
    chk("pd_pll_kept", 32'h1, 32'({cpu_en, pll_run}));
    woke = 0;
    tick(3);
    chk("quick_wake", 32'h1, woke);
    chk("quick_resume", 32'h3, 32'({cpu_en, pll_run}));
    $display("test power-down done");
    stop_test();
  end
endmodule : tb_rtcwd_top

`default_nettype wire
